//--- sgio_pin_model.sv
// external pin model for one port: board drive merged with block drive
// assumes the board drives only pins whose output enable is low
`timescale 1ns/10ps

module sgio_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drv_in,
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] ext_in,
  output logic      [W-1:0] pin_out
);
  // a driven pin shows the block level, a tri-stated one the board level
  assign pin_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule // sgio_pin_model

//--- sgio_pinmux.sv
// per-pin driver select between port latch and lcd segment level
// assumes segment levels come from the lcd driver on clock_in
`timescale 1ns/10ps

module sgio_pinmux #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] latch_in,
  input  wire logic [W-1:0] dir_in,
  input  wire logic [W-1:0] seg_en_in,
  input  wire logic [W-1:0] seg_level_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_out
);
  for (genvar i = 0; i < W; i++) begin : g_pin
    always_comb begin
      // segment function overrides the port driver
      pin_out[i]    = seg_en_in[i] ? seg_level_in[i] : latch_in[i];
      pin_oe_out[i] = seg_en_in[i] | ~dir_in[i];
    end
  end

endmodule // sgio_pinmux

//--- sgio_pkg.sv
// types shared by the segment-shared port block
// assumes sgio_regs.svh is on the include path
`include "sgio_regs.svh"

package sgio_pkg;
  typedef logic [`SGIO_ADDR_W-1:0] sgio_addr_t;
  typedef logic [`SGIO_DATA_W-1:0] sgio_byte_t;
  typedef logic [`SGIO_PF_W-1:0]   sgio_pf_t;
  typedef logic [`SGIO_PG_W-1:0]   sgio_pg_t;
  typedef logic [`SGIO_SEG_W-1:0]  sgio_seg_t;
endpackage

//--- sgio_regs.svh
// register offsets, reset values and field widths for the segment-shared
// port block; included by the package, by sgio_top and by the testbench
`ifndef SGIO_REGS_SVH
`define SGIO_REGS_SVH

`define SGIO_ADDR_W        3
`define SGIO_DATA_W        8
`define SGIO_PF_W          8
`define SGIO_PG_W          6
`define SGIO_SEG_W         14

`define SGIO_OFS_PF_DATA   3'h0
`define SGIO_OFS_PF_DIR    3'h1
`define SGIO_OFS_PG_DATA   3'h2
`define SGIO_OFS_PG_DIR    3'h3
`define SGIO_OFS_SE_24_31  3'h4
`define SGIO_OFS_SE_32_39  3'h5
`define SGIO_OFS_SE_40_41  3'h6

`define SGIO_PF_DIR_RST    8'hff
`define SGIO_PG_DIR_RST    6'h3f
`define SGIO_SE8_RST       8'h00
`define SGIO_SE2_RST       2'h0
`define SGIO_RDATA_RST     8'h00
`define SGIO_PG_PAD        2'h0

// segment level index = segment number minus 28
`define SGIO_SEG_IDX_PF_LO 4
`define SGIO_SEG_IDX_PF_HI 0
`define SGIO_SEG_IDX_PG    8

`endif

//--- sgio_sync.sv
// three-stage pin synchroniser, one per port
// assumes inputs are asynchronous to clock_in
`timescale 1ns/10ps

module sgio_sync #(
  parameter int W = 8
) (
  input  wire logic         clock_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] level_nxt;

  // a bit changes only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_r[i];
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_r <= '0;
    end else begin
      s1_r    <= pin_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule // sgio_sync

//--- sgio_top.sv
// ports f and g with lcd segment sharing, register port and pin muxing
// assumes a single 100 MHz clock; por_in is high while the current reset
// comes from power-on or brown-out and is on the clock_in domain
`timescale 1ns/10ps
`include "sgio_regs.svh"

// Summary of operation
// - port f read returns synchronised pin levels
// - port f direction one tri-states, zero drives
// - port g bits 5-0 read pin levels
// - port g bits 7-6 ignore writes, read zero
// - port g direction one tri-states, zero drives
// - each port g pin direction is independent
// - port f latch kept; direction resets all ones
// - port g direction resets to all ones
// - port f pins map to segments 32-35, 28-31
// - port g pins map to segments 36-41
// - segment enables clear on power-on or brown-out only
module sgio_top
  import sgio_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  input  wire logic       por_in,
  input  wire sgio_addr_t addr_in,
  input  wire sgio_byte_t wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output sgio_byte_t      rdata_out,
  input  wire sgio_pf_t   pf_pin_in,
  output sgio_pf_t        pf_pin_out,
  output sgio_pf_t        pf_pin_oe_out,
  input  wire sgio_pg_t   pg_pin_in,
  output sgio_pg_t        pg_pin_out,
  output sgio_pg_t        pg_pin_oe_out,
  input  wire sgio_seg_t  lcd_segment_output_in,
  output sgio_seg_t       seg_enable_out
);

  sgio_pf_t   pf_latch_r;
  sgio_pf_t   pf_latch_nxt;
  sgio_pg_t   pg_latch_r;
  sgio_pg_t   pg_latch_nxt;
  sgio_pf_t   pf_dir_r;
  sgio_pf_t   pf_dir_nxt;
  sgio_pg_t   pg_dir_r;
  sgio_pg_t   pg_dir_nxt;
  sgio_byte_t se3_r;
  sgio_byte_t se3_nxt;
  sgio_byte_t se4_r;
  sgio_byte_t se4_nxt;
  logic [1:0] se5_r;
  logic [1:0] se5_nxt;
  sgio_byte_t rdata_r;
  sgio_byte_t rdata_nxt;
  sgio_pf_t   pf_level;
  sgio_pg_t   pg_level;
  sgio_pf_t   pf_seg_en;
  sgio_pf_t   pf_seg_lvl;
  sgio_pg_t   pg_seg_en;
  sgio_pg_t   pg_seg_lvl;

  // pin input synchronisers
  sgio_sync #(.W(`SGIO_PF_W)) u_pf_sync (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .pin_in    (pf_pin_in),
    .level_out (pf_level)
  );

  sgio_sync #(.W(`SGIO_PG_W)) u_pg_sync (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .pin_in    (pg_pin_in),
    .level_out (pg_level)
  );

  // latch and segment enables: no async reset, survive warm resets
  always_comb begin
    pf_latch_nxt = pf_latch_r;
    pg_latch_nxt = pg_latch_r;
    se3_nxt      = se3_r;
    se4_nxt      = se4_r;
    se5_nxt      = se5_r;
    if (wr_in) begin
      unique case (addr_in)
        `SGIO_OFS_PF_DATA:  pf_latch_nxt = wdata_in;
        `SGIO_OFS_PG_DATA:  pg_latch_nxt = wdata_in[`SGIO_PG_W-1:0];
        `SGIO_OFS_SE_24_31: se3_nxt      = wdata_in;
        `SGIO_OFS_SE_32_39: se4_nxt      = wdata_in;
        `SGIO_OFS_SE_40_41: se5_nxt      = wdata_in[1:0];
        default: ;
      endcase
    end
    if (por_in) begin
      se3_nxt = `SGIO_SE8_RST;
      se4_nxt = `SGIO_SE8_RST;
      se5_nxt = `SGIO_SE2_RST;
    end
  end

  always_ff @(posedge clock_in) begin
    pf_latch_r <= pf_latch_nxt;
    pg_latch_r <= pg_latch_nxt;
    se3_r      <= se3_nxt;
    se4_r      <= se4_nxt;
    se5_r      <= se5_nxt;
  end

  // direction registers and read data
  always_comb begin
    pf_dir_nxt = pf_dir_r;
    pg_dir_nxt = pg_dir_r;
    rdata_nxt  = `SGIO_RDATA_RST;
    if (wr_in) begin
      unique case (addr_in)
        `SGIO_OFS_PF_DIR: pf_dir_nxt = wdata_in;
        `SGIO_OFS_PG_DIR: pg_dir_nxt = wdata_in[`SGIO_PG_W-1:0];
        default: ;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        `SGIO_OFS_PF_DATA:  rdata_nxt = pf_level;
        `SGIO_OFS_PF_DIR:   rdata_nxt = pf_dir_r;
        `SGIO_OFS_PG_DATA:  rdata_nxt = {`SGIO_PG_PAD, pg_level};
        `SGIO_OFS_PG_DIR:   rdata_nxt = {`SGIO_PG_PAD, pg_dir_r};
        `SGIO_OFS_SE_24_31: rdata_nxt = se3_r;
        `SGIO_OFS_SE_32_39: rdata_nxt = se4_r;
        `SGIO_OFS_SE_40_41: rdata_nxt = {6'h00, se5_r};
        default:            rdata_nxt = `SGIO_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pf_dir_r <= `SGIO_PF_DIR_RST;
      pg_dir_r <= `SGIO_PG_DIR_RST;
      rdata_r  <= `SGIO_RDATA_RST;
    end else begin
      pf_dir_r <= pf_dir_nxt;
      pg_dir_r <= pg_dir_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign rdata_out = rdata_r;

  // segment routing to pins
  always_comb begin
    pf_seg_en  = {se3_r[7:4], se4_r[3:0]};
    pf_seg_lvl = {lcd_segment_output_in[`SGIO_SEG_IDX_PF_HI +: 4],
                  lcd_segment_output_in[`SGIO_SEG_IDX_PF_LO +: 4]};
    pg_seg_en  = {se5_r, se4_r[7:4]};
    pg_seg_lvl = lcd_segment_output_in[`SGIO_SEG_IDX_PG +: `SGIO_PG_W];
  end

  sgio_pinmux #(.W(`SGIO_PF_W)) u_pf_mux (
    .latch_in     (pf_latch_r),
    .dir_in       (pf_dir_r),
    .seg_en_in    (pf_seg_en),
    .seg_level_in (pf_seg_lvl),
    .pin_out      (pf_pin_out),
    .pin_oe_out   (pf_pin_oe_out)
  );

  sgio_pinmux #(.W(`SGIO_PG_W)) u_pg_mux (
    .latch_in     (pg_latch_r),
    .dir_in       (pg_dir_r),
    .seg_en_in    (pg_seg_en),
    .seg_level_in (pg_seg_lvl),
    .pin_out      (pg_pin_out),
    .pin_oe_out   (pg_pin_oe_out)
  );

  assign seg_enable_out = {se5_r, se4_r, se3_r[7:4]};

  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  pf_read_pin_a: assert property (
    $stable(pf_pin_in) [*6] ##0 (rd_in && addr_in == `SGIO_OFS_PF_DATA)
    |=> rdata_out == $past(pf_pin_in))
    else $error("port f read does not match pin level");

  pf_dir_drive_a: assert property (
    (wr_in && addr_in == `SGIO_OFS_PF_DIR && pf_seg_en == 8'h00)
    |=> pf_pin_oe_out == ~$past(wdata_in))
    else $error("port f enables do not follow direction write");

  pg_read_pin_a: assert property (
    $stable(pg_pin_in) [*6] ##0 (rd_in && addr_in == `SGIO_OFS_PG_DATA)
    |=> rdata_out == {2'h0, $past(pg_pin_in)})
    else $error("port g read does not match pin level");

  pg_high_zero_a: assert property (
    rd_in && (addr_in == `SGIO_OFS_PG_DATA || addr_in == `SGIO_OFS_PG_DIR)
    |=> rdata_out[7:6] == 2'h0)
    else $error("port g upper bits read nonzero");

  pg_dir_drive_a: assert property (
    (wr_in && addr_in == `SGIO_OFS_PG_DIR && pg_seg_en == 6'h00)
    |=> pg_pin_oe_out == ~$past(wdata_in[5:0]))
    else $error("port g enables do not follow direction write");

  pg_dir_indep_a: assert property (
    (wr_in && addr_in == `SGIO_OFS_PG_DIR)
    |=> pg_dir_r == $past(wdata_in[5:0]) ##1 $stable(pg_dir_r)
        || $past(wr_in))
    else $error("port g direction write not bitwise");

  pf_dir_reset_a: assert property (disable iff (1'b0)
    $rose(nrst_in) |-> pf_dir_r == `SGIO_PF_DIR_RST)
    else $error("port f direction not all ones after reset");

  pg_dir_reset_a: assert property (disable iff (1'b0)
    $rose(nrst_in) |-> pg_dir_r == `SGIO_PG_DIR_RST)
    else $error("port g direction not all ones after reset");

  pf_seg_map_a: assert property (
    se4_r[0] && se3_r[4] |-> pf_pin_out[0] == lcd_segment_output_in[4]
      && pf_pin_out[4] == lcd_segment_output_in[0]
      && pf_pin_oe_out[0] && pf_pin_oe_out[4])
    else $error("port f segment mapping wrong");

  pg_seg_map_a: assert property (
    se4_r[4] && se5_r[1] |-> pg_pin_out[0] == lcd_segment_output_in[8]
      && pg_pin_out[5] == lcd_segment_output_in[13])
    else $error("port g segment mapping wrong");

  seg_por_clear_a: assert property (disable iff (1'b0)
    por_in |=> se3_r == 8'h00 && se4_r == 8'h00 && se5_r == 2'h0)
    else $error("segment enables not cleared on power-on");

  seg_keep_a: assert property (disable iff (1'b0)
    !por_in && !wr_in |=> $stable(se3_r) && $stable(se4_r)
      && $stable(se5_r))
    else $error("segment enables changed without write");

  pf_latch_out_a: assert property (
    (wr_in && addr_in == `SGIO_OFS_PF_DATA && pf_seg_en == 8'h00)
    ##1 (!wr_in && pf_seg_en == 8'h00)
    |-> pf_pin_out == $past(wdata_in))
    else $error("port f output does not follow latch write");

  pf_latch_load_a: assert property (
    wr_in && addr_in == `SGIO_OFS_PF_DATA
    |=> pf_latch_r == $past(wdata_in))
    else $error("port f latch does not take write data");

  pg_data_mask_a: assert property (
    wr_in && addr_in == `SGIO_OFS_PG_DATA
    |=> pg_latch_r == $past(wdata_in[5:0]))
    else $error("port g latch does not take low write bits");

  pg_latch_out_a: assert property (
    (wr_in && addr_in == `SGIO_OFS_PG_DATA && pg_seg_en == 6'h00)
    ##1 (!wr_in && pg_seg_en == 6'h00)
    |-> pg_pin_out == $past(wdata_in[5:0]))
    else $error("port g output does not follow latch write");

  pf_dir_read_a: assert property (
    rd_in && addr_in == `SGIO_OFS_PF_DIR
    |=> rdata_out == $past(pf_dir_r))
    else $error("port f direction read back wrong");

  rdata_idle_a: assert property (
    !rd_in
    |=> rdata_out == 8'h00)
    else $error("read data not zero outside answer cycle");

  // per-pin driver select, port f: pins 0-3 on enable reg 32-39
  for (genvar i = 0; i < `SGIO_PF_W; i++) begin : g_pf_chk
    pf_pin_seg_a: assert property (
      ((i < 4) ? se4_r[i] : se3_r[i])
      |-> pf_pin_out[i] == lcd_segment_output_in[i ^ 4]
          && pf_pin_oe_out[i])
      else $error("port f pin does not follow its segment");
    pf_pin_dir_a: assert property (
      !((i < 4) ? se4_r[i] : se3_r[i])
      |-> pf_pin_oe_out[i] == !pf_dir_r[i])
      else $error("port f pin enable does not follow its direction bit");
  end

  // per-pin driver select, port g: segments 36-41 in order
  for (genvar i = 0; i < `SGIO_PG_W; i++) begin : g_pg_chk
    pg_pin_seg_a: assert property (
      ((i < 4) ? se4_r[(i + 4) % 8] : se5_r[i % 2])
      |-> pg_pin_out[i] == lcd_segment_output_in[i + 8]
          && pg_pin_oe_out[i])
      else $error("port g pin does not follow its segment");
    pg_pin_dir_a: assert property (
      !((i < 4) ? se4_r[(i + 4) % 8] : se5_r[i % 2])
      |-> pg_pin_oe_out[i] == !pg_dir_r[i])
      else $error("port g pin enable does not follow its direction bit");
  end

  wr_read_cov: cover property (
    wr_in && addr_in == `SGIO_OFS_PF_DATA ##1 rd_in);
  seg_on_cov: cover property ($rose(se4_r[0]));
  por_cov: cover property (por_in ##1 !por_in);
  pg_out_cov: cover property (pg_pin_oe_out == 6'h3f);

endmodule // sgio_top

//--- tb.sv
// register and pin tests for the segment-shared port block
// assumes sgio_regs.svh on the include path and the pin model alongside
`timescale 1ns/10ps
`include "sgio_regs.svh"

module tb
  import sgio_pkg::*;
;
  logic       clock_in = 1'b0;
  logic       nrst_in  = 1'b0;
  logic       por_in   = 1'b1;
  sgio_addr_t addr     = 3'h0;
  sgio_byte_t wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  sgio_byte_t rdata;
  sgio_pf_t   pf_in, pf_out, pf_oe;
  sgio_pf_t   pf_ext   = 8'h00;
  sgio_pg_t   pg_in, pg_out, pg_oe;
  sgio_pg_t   pg_ext   = 6'h00;
  sgio_seg_t  lcd      = 14'h0000;
  sgio_seg_t  seg_en;
  int         fails    = 0;
  int         checks   = 0;

  always #5 clock_in = ~clock_in;

  sgio_top i_sgio_top (.clock_in(clock_in), .nrst_in(nrst_in),
    .por_in(por_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .pf_pin_in(pf_in),
    .pf_pin_out(pf_out), .pf_pin_oe_out(pf_oe), .pg_pin_in(pg_in),
    .pg_pin_out(pg_out), .pg_pin_oe_out(pg_oe),
    .lcd_segment_output_in(lcd), .seg_enable_out(seg_en));
  sgio_pin_model #(.W(8)) i_sgio_pin_model_f (.drv_in(pf_out),
    .oe_in(pf_oe), .ext_in(pf_ext), .pin_out(pf_in));
  sgio_pin_model #(.W(6)) i_sgio_pin_model_g (.drv_in(pg_out),
    .oe_in(pg_oe), .ext_in(pg_ext), .pin_out(pg_in));

  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input sgio_addr_t a, input sgio_byte_t d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input sgio_addr_t a, input sgio_byte_t exp);
    @(posedge clock_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    chk("rdata", 16'(rdata), 16'(exp));
  endtask

  task automatic do_reset(input logic por);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    por_in <= por;
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    por_in <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    do_reset(1'b1);
    rd_reg(`SGIO_OFS_PF_DIR, 8'hff);
    rd_reg(`SGIO_OFS_PG_DIR, 8'h3f);
    rd_reg(`SGIO_OFS_SE_24_31, 8'h00);
    rd_reg(`SGIO_OFS_SE_32_39, 8'h00);
    rd_reg(3'h7, 8'h00);
    chk("pf_oe", 16'(pf_oe), 16'h0000);
    chk("pg_oe", 16'(pg_oe), 16'h0000);
    // input levels read back through the synchroniser
    pf_ext <= 8'h96;
    pg_ext <= 6'h29;
    repeat (6) @(posedge clock_in);
    rd_reg(`SGIO_OFS_PF_DATA, 8'h96);
    rd_reg(`SGIO_OFS_PG_DATA, 8'h29);
    // unimplemented high bits of port g
    wr_reg(`SGIO_OFS_PG_DIR, 8'hc0);
    rd_reg(`SGIO_OFS_PG_DIR, 8'h00);
    chk("pg_oe", 16'(pg_oe), 16'h003f);
    wr_reg(`SGIO_OFS_PG_DIR, 8'hff);
    rd_reg(`SGIO_OFS_PG_DIR, 8'h3f);
    // latch drives only pins with direction zero
    wr_reg(`SGIO_OFS_PF_DATA, 8'ha5);
    wr_reg(`SGIO_OFS_PF_DIR, 8'h0f);
    chk("pf_oe", 16'(pf_oe), 16'h00f0);
    chk("pf_out", 16'(pf_out & pf_oe), 16'h00a0);
    repeat (6) @(posedge clock_in);
    rd_reg(`SGIO_OFS_PF_DATA, 8'ha6);
    wr_reg(`SGIO_OFS_PG_DATA, 8'hea);
    for (int i = 0; i < 6; i++) begin
      wr_reg(`SGIO_OFS_PG_DIR, 8'(~(8'h01 << i)));
      chk("pg_oe", 16'(pg_oe), 16'(6'h01 << i));
      chk("pg_out", 16'(pg_out & pg_oe), 16'(6'h2a & (6'h01 << i)));
    end
    wr_reg(`SGIO_OFS_PG_DIR, 8'hff);
    // segment functions take over the pins
    lcd <= 14'h2d3c;
    wr_reg(`SGIO_OFS_SE_24_31, 8'hf0);
    wr_reg(`SGIO_OFS_SE_32_39, 8'hff);
    wr_reg(`SGIO_OFS_SE_40_41, 8'h03);
    chk("seg_en", 16'(seg_en), 16'h3fff);
    chk("pf_oe", 16'(pf_oe), 16'h00ff);
    chk("pf_out", 16'(pf_out), 16'h00c3);
    chk("pg_oe", 16'(pg_oe), 16'h003f);
    chk("pg_out", 16'(pg_out), 16'h002d);
    wr_reg(`SGIO_OFS_SE_32_39, 8'h00);
    wr_reg(`SGIO_OFS_SE_40_41, 8'h00);
    // warm reset keeps latch and enables, restores direction
    do_reset(1'b0);
    #1;
    rd_reg(`SGIO_OFS_PF_DIR, 8'hff);
    rd_reg(`SGIO_OFS_SE_24_31, 8'hf0);
    wr_reg(`SGIO_OFS_SE_24_31, 8'h00);
    wr_reg(`SGIO_OFS_PF_DIR, 8'h00);
    chk("pf_out", 16'(pf_out), 16'h00a5);
    wr_reg(`SGIO_OFS_SE_24_31, 8'hf0);
    do_reset(1'b1);
    #1;
    chk("seg_en", 16'(seg_en), 16'h0000);
    rd_reg(`SGIO_OFS_SE_24_31, 8'h00);
    rd_reg(`SGIO_OFS_PG_DIR, 8'h3f);
    results();
  end
endmodule // tb
